// file: dual_port_ram_width_convert.sv
// Width-converting dual-port block RAM of 4,608 bits with separate write and read ports.
// Assumes port clocks and all port inputs are levels synchronous to ref_clk.
//
// Notes on behaviour
// - Write and read ports each pick their own width and depth independently.
// - Width selects are live inputs; each access uses the select present then.
// - Codes 000 to 101 give 4kx1 to 128x36; 11x are reserved: the access does nothing but raise width_fault.
// - At 1, 2 or 4-bit width the ninth bit of each group is untouched.
// - Nine-bit writes read as 4-bit halves; the ninth bit is not returned at 4-bit width.
// - Four-bit writes read as nine bits return the ninth bit as it was before.
// - Array holds 4,608 bits; address shrinks from 12 bits to 7 bits.
// - A write and a read may happen in the same cycle independently.
// - Each port clock has its own active edge polarity select.
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_width_convert
   import ram_width_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire write_req_t write_req,
   input wire logic write_clk_in,
   input wire logic write_clk_falling,
   input wire read_req_t read_req,
   input wire logic read_clk_in,
   input wire logic read_clk_falling,
   output logic [ROW_BITS-1:0] read_port_data,
   output logic read_data_valid,
   output logic width_fault
);

   ////////////////////////////////////////////////////////////////////////////////
   // Storage: 128 rows of 36 bits, each row four 9-bit groups.
   // The array has no reset; contents are undefined until written.

   logic [ROW_BITS-1:0] mem [0:ROW_COUNT-1];

   ram_state_t state_r;
   ram_state_t state_nxt;

   logic write_edge;
   logic read_edge;
   logic write_fire;
   logic read_fire;

   logic [ROW_ADDR_BITS-1:0] wr_row;
   logic [SHIFT_BITS-1:0] wr_shift;
   logic [ROW_BITS-1:0] wr_data_mask;
   logic [ROW_BITS-1:0] wr_lane_mask;
   logic wr_width_ok;

   logic [ROW_ADDR_BITS-1:0] rd_row;
   logic [SHIFT_BITS-1:0] rd_shift;
   logic [ROW_BITS-1:0] rd_data_mask;
   logic [ROW_BITS-1:0] rd_lane_mask;
   logic rd_width_ok;

   logic [ROW_BITS-1:0] wr_row_data;
   logic [ROW_BITS-1:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////////
   // Address mapping, one instance per port, so each port sees its own width.

   ram_lane_map write_map (
      .width_sel(write_req.write_width_select),
      .addr(write_req.write_port_address),
      .row(wr_row),
      .shift(wr_shift),
      .data_mask(wr_data_mask),
      .lane_mask(wr_lane_mask),
      .width_ok(wr_width_ok)
   );

   ram_lane_map read_map (
      .width_sel(read_req.read_width_select),
      .addr(read_req.read_port_address),
      .row(rd_row),
      .shift(rd_shift),
      .data_mask(rd_data_mask),
      .lane_mask(rd_lane_mask),
      .width_ok(rd_width_ok)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Port clock edges. A port clock is sampled on ref_clk, so it must run well
   // below half of ref_clk; edges faster than that are lost.

   always_comb begin
      if (write_clk_falling) begin
         write_edge = state_r.write_clk_prev_r & ~write_clk_in;
      end else begin
         write_edge = ~state_r.write_clk_prev_r & write_clk_in;
      end
      if (read_clk_falling) begin
         read_edge = state_r.read_clk_prev_r & ~read_clk_in;
      end else begin
         read_edge = ~state_r.read_clk_prev_r & read_clk_in;
      end
   end

   // Reserved width codes turn the access into a no-operation.
   assign write_fire = write_edge & write_req.write_enable & wr_width_ok;
   assign read_fire = read_edge & read_req.read_enable & rd_width_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // Write path: only the lanes of the selected word change, so narrow writes
   // leave the ninth bit of each group as it was.

   assign wr_row_data = ROW_BITS'(write_req.write_port_data & wr_data_mask) << wr_shift;

   always_ff @(posedge ref_clk) begin
      if (write_fire) begin
         mem[wr_row] <= (mem[wr_row] & ~wr_lane_mask) | (wr_row_data & wr_lane_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: the ninth bit is only returned at 9-bit or wider read widths.
   // A read of a row written in the same cycle returns the old contents; the
   // two ports never stall each other.

   assign rd_word = (mem[rd_row] >> rd_shift) & rd_data_mask;

   always_comb begin
      state_nxt = state_r;
      state_nxt.write_clk_prev_r = write_clk_in;
      state_nxt.read_clk_prev_r = read_clk_in;
      state_nxt.read_data_valid_r = read_fire;
      if (read_fire) begin
         state_nxt.read_port_data_r = rd_word;
      end
      if ((write_edge & write_req.write_enable & ~wr_width_ok)
            | (read_edge & read_req.read_enable & ~rd_width_ok)) begin
         state_nxt.width_fault_r = 1'b1;
      end else if (write_fire | read_fire) begin
         state_nxt.width_fault_r = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_r.write_clk_prev_r <= 1'b0;
         state_r.read_clk_prev_r <= 1'b0;
         state_r.read_port_data_r <= DATA_RESET;
         state_r.read_data_valid_r <= 1'b0;
         state_r.width_fault_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign read_port_data = state_r.read_port_data_r;
   assign read_data_valid = state_r.read_data_valid_r;
   assign width_fault = state_r.width_fault_r;

endmodule
`default_nettype wire

// file: ram_width_pkg.sv
// Shared constants and carrier types of the width-converting dual-port RAM.
// Assumes one system clock; port clocks arrive as sampled levels on that clock.
package ram_width_pkg;

   localparam int ROW_BITS = 36;
   localparam int ROW_COUNT = 128;
   localparam int ROW_ADDR_BITS = 7;
   localparam int GROUP_BITS = 9;
   localparam int GROUP_IDX_BITS = 9;
   localparam int SLOT_BITS = 2;
   localparam int ADDR_BITS = 12;
   localparam int SHIFT_BITS = 6;
   localparam int OFF_BITS = 3;

   // Address bits that pick a narrow word inside one 9-bit group.
   localparam int SUB_BITS_W1 = 3;
   localparam int SUB_BITS_W2 = 2;
   localparam int SUB_BITS_W4 = 1;
   // Groups spanned by one wide word, as a power of two.
   localparam int GROUPS_LOG_W18 = 1;
   localparam int GROUPS_LOG_W36 = 2;

   // Bit step between neighbouring narrow words inside one group, and between neighbouring groups.
   localparam logic [OFF_BITS-1:0] STEP_W1 = 3'h1;
   localparam logic [OFF_BITS-1:0] STEP_W2 = 3'h2;
   localparam logic [OFF_BITS-1:0] STEP_W4 = 3'h4;
   localparam logic [SHIFT_BITS-1:0] GROUP_STRIDE = 6'h09;

   localparam logic [ROW_BITS-1:0] MASK_W1 = 36'h0_0000_0001;
   localparam logic [ROW_BITS-1:0] MASK_W2 = 36'h0_0000_0003;
   localparam logic [ROW_BITS-1:0] MASK_W4 = 36'h0_0000_000F;
   localparam logic [ROW_BITS-1:0] MASK_W9 = 36'h0_0000_01FF;
   localparam logic [ROW_BITS-1:0] MASK_W18 = 36'h0_0003_FFFF;
   localparam logic [ROW_BITS-1:0] MASK_W36 = 36'hF_FFFF_FFFF;
   localparam logic [ROW_BITS-1:0] DATA_RESET = 36'h0_0000_0000;

   typedef enum logic [2:0] {
      WIDTH_4K_X1 = 3'b000,
      WIDTH_2K_X2 = 3'b001,
      WIDTH_1K_X4 = 3'b010,
      WIDTH_512_X9 = 3'b011,
      WIDTH_256_X18 = 3'b100,
      WIDTH_128_X36 = 3'b101,
      WIDTH_RSVD_A = 3'b110,
      WIDTH_RSVD_B = 3'b111
   } width_code_t;

   typedef struct packed {
      logic write_enable;
      width_code_t write_width_select;
      logic [ADDR_BITS-1:0] write_port_address;
      logic [ROW_BITS-1:0] write_port_data;
   } write_req_t;

   typedef struct packed {
      logic read_enable;
      width_code_t read_width_select;
      logic [ADDR_BITS-1:0] read_port_address;
   } read_req_t;

   typedef struct packed {
      logic write_clk_prev_r;
      logic read_clk_prev_r;
      logic [ROW_BITS-1:0] read_port_data_r;
      logic read_data_valid_r;
      logic width_fault_r;
   } ram_state_t;

endpackage

// file: ram_lane_map.sv
// Maps one port's width select and address onto a row, a bit shift and lane masks.
// Assumes the storage is a set of 36-bit rows, each four 9-bit groups.
`timescale 1ns/1ps
`default_nettype none
module ram_lane_map
   import ram_width_pkg::*;
(
   input wire width_code_t width_sel,
   input wire logic [ADDR_BITS-1:0] addr,
   output logic [ROW_ADDR_BITS-1:0] row,
   output logic [SHIFT_BITS-1:0] shift,
   output logic [ROW_BITS-1:0] data_mask,
   output logic [ROW_BITS-1:0] lane_mask,
   output logic width_ok
);

   logic [GROUP_IDX_BITS-1:0] group_idx;
   logic [OFF_BITS-1:0] off;
   logic [SLOT_BITS-1:0] slot;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      group_idx = '0;
      off = '0;
      data_mask = '0;
      width_ok = 1'b1;
      // Narrow words step through bits 0..7 of a group only, never bit 8.
      case (width_sel)
         WIDTH_4K_X1: begin
            group_idx = GROUP_IDX_BITS'(addr >> SUB_BITS_W1);
            off = OFF_BITS'(addr[SUB_BITS_W1-1:0]) * STEP_W1;
            data_mask = MASK_W1;
         end
         WIDTH_2K_X2: begin
            group_idx = GROUP_IDX_BITS'(addr >> SUB_BITS_W2);
            off = OFF_BITS'(addr[SUB_BITS_W2-1:0]) * STEP_W2;
            data_mask = MASK_W2;
         end
         WIDTH_1K_X4: begin
            group_idx = GROUP_IDX_BITS'(addr >> SUB_BITS_W4);
            off = OFF_BITS'(addr[SUB_BITS_W4-1:0]) * STEP_W4;
            data_mask = MASK_W4;
         end
         WIDTH_512_X9: begin
            group_idx = GROUP_IDX_BITS'(addr);
            data_mask = MASK_W9;
         end
         WIDTH_256_X18: begin
            group_idx = GROUP_IDX_BITS'(addr << GROUPS_LOG_W18);
            data_mask = MASK_W18;
         end
         WIDTH_128_X36: begin
            group_idx = GROUP_IDX_BITS'(addr << GROUPS_LOG_W36);
            data_mask = MASK_W36;
         end
         default: begin
            width_ok = 1'b0;
         end
      endcase
      row = ROW_ADDR_BITS'(group_idx >> SLOT_BITS);
      slot = group_idx[SLOT_BITS-1:0];
      shift = SHIFT_BITS'(slot) * GROUP_STRIDE + SHIFT_BITS'(off);
      lane_mask = data_mask << shift;
   end

endmodule
`default_nettype wire

// file: ram_width_chk.sv
// Concurrent checks on the ports of the width-converting dual-port RAM.
// Assumes the design's edge history starts at 0 out of reset, as this copy does.
`timescale 1ns/1ps
`default_nettype none
module ram_width_chk
   import ram_width_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire write_req_t write_req,
   input wire logic write_clk_in,
   input wire logic write_clk_falling,
   input wire read_req_t read_req,
   input wire logic read_clk_in,
   input wire logic read_clk_falling,
   input wire logic [ROW_BITS-1:0] read_port_data,
   input wire logic read_data_valid,
   input wire logic width_fault
);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic wprev_r;
   logic rprev_r;
   logic wr_edge, rd_edge, wr_ok, rd_ok, wr_take, rd_take, wr_bad, rd_bad;
   always_ff @(posedge ref_clk) begin
      wprev_r <= reset_n & write_clk_in;
      rprev_r <= reset_n & read_clk_in;
   end
   assign wr_edge = write_clk_falling ? (wprev_r & ~write_clk_in) : (~wprev_r & write_clk_in);
   assign rd_edge = read_clk_falling ? (rprev_r & ~read_clk_in) : (~rprev_r & read_clk_in);
   assign wr_ok = ~(write_req.write_width_select[2] & write_req.write_width_select[1]);
   assign rd_ok = ~(read_req.read_width_select[2] & read_req.read_width_select[1]);
   assign wr_take = wr_edge & write_req.write_enable & wr_ok;
   assign rd_take = rd_edge & read_req.read_enable & rd_ok;
   assign wr_bad = wr_edge & write_req.write_enable & ~wr_ok;
   assign rd_bad = rd_edge & read_req.read_enable & ~rd_ok;
   ////////////////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_rd_take;
      rd_take;
   endsequence
   sequence s_rd_answer;
      read_data_valid ##1 !read_data_valid;
   endsequence
   chk_read_answer: assert property (s_rd_take |=> s_rd_answer)
      else $error("Read answer missing or not one cycle.");
   chk_valid_cause: assert property (read_data_valid |-> $past(rd_take))
      else $error("Read data valid without an accepted read.");
   chk_read_refused: assert property (rd_bad |=> !read_data_valid && width_fault)
      else $error("Reserved read width was not refused.");
   chk_write_refused: assert property (wr_bad |=> width_fault)
      else $error("Reserved write width raised no fault.");
   chk_fault_clear: assert property ((wr_take || rd_take) && !wr_bad && !rd_bad |=> !width_fault)
      else $error("Fault not cleared by a good access.");
   chk_data_hold: assert property (!read_data_valid |-> $stable(read_port_data))
      else $error("Read data moved without a read.");
   chk_four_zero: assert property (s_rd_take and read_req.read_width_select == WIDTH_1K_X4
      |=> read_port_data[35:4] == 32'h0000_0000)
      else $error("Four-bit read shows bits above its width.");
   chk_nine_zero: assert property (s_rd_take and read_req.read_width_select == WIDTH_512_X9
      |=> read_port_data[35:9] == 27'h000_0000)
      else $error("Nine-bit read shows bits above its width.");
   chk_one_zero: assert property (s_rd_take and read_req.read_width_select == WIDTH_4K_X1
      |=> read_port_data[35:1] == 35'h0_0000_0000)
      else $error("One-bit read shows bits above its width.");
endmodule
bind dual_port_ram_width_convert ram_width_chk chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
   .write_req(write_req), .write_clk_in(write_clk_in), .write_clk_falling(write_clk_falling),
   .read_req(read_req), .read_clk_in(read_clk_in), .read_clk_falling(read_clk_falling),
   .read_port_data(read_port_data), .read_data_valid(read_data_valid), .width_fault(width_fault));
`default_nettype wire

// file: fabric_clk_model.sv
// Fabric-side port clock source: one active clock pulse per request.
// Assumes requests are single-cycle and at least four cycles apart.
`timescale 1ns/1ps
`default_nettype none
module fabric_clk_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic go,
   input wire logic falling,
   output logic port_clk
);
   logic [1:0] cnt_r;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) cnt_r <= 2'h0;
      else if (go) cnt_r <= 2'h2;
      else if (cnt_r != 2'h0) cnt_r <= cnt_r - 2'h1;
   end
   // Idle level follows the polarity, so a polarity change while idle never looks like an active edge.
   assign port_clk = falling ^ (cnt_r != 2'h0);
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the width-converting dual-port RAM.
// Assumes both port clocks come from the fabric clock model.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ram_width_pkg::*;
   logic ref_clk = 0, reset_n = 0, wgo = 0, rgo = 0, fall = 0;
   write_req_t wr = '0;
   read_req_t rd = '0;
   logic wclk, rclk, rvalid, fault;
   logic [ROW_BITS-1:0] rdata;
   int num_errors = 0, cmp_count = 0;
   always #10 ref_clk = ~ref_clk;
   fabric_clk_model wmod (.ref_clk(ref_clk), .reset_n(reset_n), .go(wgo), .falling(fall),
      .port_clk(wclk));
   fabric_clk_model rmod (.ref_clk(ref_clk), .reset_n(reset_n), .go(rgo), .falling(fall),
      .port_clk(rclk));
   dual_port_ram_width_convert dut (.ref_clk(ref_clk), .reset_n(reset_n), .write_req(wr),
      .write_clk_in(wclk), .write_clk_falling(fall), .read_req(rd), .read_clk_in(rclk),
      .read_clk_falling(fall), .read_port_data(rdata), .read_data_valid(rvalid),
      .width_fault(fault));
   ////////////////////////////////////////////////////////////////////////////////////////////////
   task check(input logic [35:0] seen, input logic [35:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("Mismatches %0d, compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task do_write(input width_code_t c, input logic [11:0] a, input logic [35:0] d);
      wr = '{1'b1, c, a, d};
      wgo = 1;
      step(1);
      wgo = 0;
      step(3);
      wr.write_enable = 0;
   endtask
   // A bounded wait: a good read that never answers ends the run.
   task do_read(input width_code_t c, input logic [11:0] a, input logic [35:0] exp,
      input logic [35:0] m, input bit good);
      bit seen;
      seen = 0;
      rd = '{1'b1, c, a};
      rgo = 1;
      step(1);
      rgo = 0;
      for (int i = 0; i < 6; i++) begin
         step(1);
         if (rvalid === 1'b1 && !seen && good) check(rdata & m, exp);
         if (rvalid === 1'b1) seen = 1;
      end
      rd.read_enable = 0;
      check({35'h0, seen}, {35'h0, good});
      if (!good) check({35'h0, fault}, 36'h0_0000_0001);
      if (good && !seen) print_verdict;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////////
   task sc_all_widths;
      int w[6] = '{1, 2, 4, 9, 18, 36};
      logic [35:0] m;
      logic [11:0] a;
      for (int c = 0; c < 6; c++) begin
         m = (36'h0_0000_0001 << w[c]) - 36'h0_0000_0001;
         a = 12'((70 + 5 * c) << (5 - c));
         do_write(width_code_t'(c[2:0]), a, 36'h9_C3A5_5A6B);
         do_read(width_code_t'(c[2:0]), a, 36'h9_C3A5_5A6B & m, m, 1);
      end
   endtask
   task sc_wide_to_narrow;
      do_write(WIDTH_256_X18, 12'h003, 36'h0_0002_5A3C);
      do_read(WIDTH_512_X9, 12'h006, 36'h0_0000_003C, MASK_W9, 1);
      do_read(WIDTH_512_X9, 12'h007, 36'h0_0000_012D, MASK_W9, 1);
   endtask
   task sc_ninth_bit;
      do_write(WIDTH_512_X9, 12'h014, 36'h0_0000_01A5);
      do_read(WIDTH_1K_X4, 12'h028, 36'h0_0000_0005, MASK_W4, 1);
      do_read(WIDTH_1K_X4, 12'h029, 36'h0_0000_000A, MASK_W4, 1);
      do_write(WIDTH_1K_X4, 12'h028, 36'h0_0000_0003);
      do_read(WIDTH_512_X9, 12'h014, 36'h0_0000_01A3, MASK_W9, 1);
      do_write(WIDTH_1K_X4, 12'h03C, 36'h0_0000_0006);
      do_write(WIDTH_1K_X4, 12'h03D, 36'h0_0000_0009);
      do_read(WIDTH_512_X9, 12'h01E, 36'h0_0000_0096, 36'h0_0000_00FF, 1);
   endtask
   task sc_reserved;
      do_read(WIDTH_RSVD_A, 12'h006, 36'h0_0000_0000, 36'h0_0000_0000, 0);
      do_write(WIDTH_RSVD_B, 12'h006, 36'hF_FFFF_FFFF);
      check({35'h0, fault}, 36'h0_0000_0001);
      do_read(WIDTH_512_X9, 12'h006, 36'h0_0000_003C, MASK_W9, 1);
      check({35'h0, fault}, 36'h0_0000_0000);
   endtask
   // Write and read of one group share an edge; the read must see the old word.
   task sc_same_cycle;
      bit seen;
      seen = 0;
      wr = '{1'b1, WIDTH_512_X9, 12'h006, 36'h0_0000_0155};
      rd = '{1'b1, WIDTH_512_X9, 12'h006};
      wgo = 1;
      rgo = 1;
      step(1);
      wgo = 0;
      rgo = 0;
      for (int i = 0; i < 6; i++) begin
         step(1);
         if (rvalid === 1'b1 && !seen) check(rdata & MASK_W9, 36'h0_0000_003C);
         if (rvalid === 1'b1) seen = 1;
      end
      wr.write_enable = 0;
      rd.read_enable = 0;
      check({35'h0, seen}, 36'h0_0000_0001);
      if (!seen) print_verdict;
      do_read(WIDTH_512_X9, 12'h006, 36'h0_0000_0155, MASK_W9, 1);
   endtask
   task sc_falling;
      fall = 1;
      step(3);
      do_write(WIDTH_128_X36, 12'h07F, 36'hA_5A5A_0F0F);
      do_read(WIDTH_128_X36, 12'h07F, 36'hA_5A5A_0F0F, MASK_W36, 1);
      fall = 0;
      step(3);
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      #1 reset_n = 1;
      sc_all_widths();
      sc_wide_to_narrow();
      sc_ninth_bit();
      sc_reserved();
      sc_same_cycle();
      sc_falling();
      print_verdict();
   end
endmodule
`default_nettype wire
